//--- core/fop_pkg.sv
// constants, state and carrier types for the flash option protection block
// assumes a 32-bit APB slave port and a byte-wide option block read port
package fop_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_WAIT = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STAT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_OPTST = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_WP = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_XCFG = 12'h024;
  localparam int STAT_PFAIL_BIT = 2;
  localparam int STAT_VIOL_BIT = 4;
  localparam int CTRL_ERR_EN_BIT = 10;
  localparam int CTRL_RELOAD_BIT = 13;
  localparam int XCFG_WAIT_EN_BIT = 0;
  localparam int OPTST_ERR_BIT = 0;
  localparam int OPTST_LVL_LSB = 1;
  localparam int OPTST_USER_LSB = 8;
  localparam int OPTST_DATA_LSB = 16;
  localparam logic [31:0] OB_BASE_ADDR = 32'h1FFF_F800;
  localparam int OB_COUNT = 12;
  localparam logic [3:0] OB_SEC = 4'h0;
  localparam logic [3:0] OB_SEC_INV = 4'h1;
  localparam logic [3:0] OB_LAST = 4'hC;
  localparam int PAIR_SEC = 0;
  localparam int PAIR_USER = 1;
  localparam int PAIR_DATA_LO = 2;
  localparam int PAIR_DATA_HI = 3;
  localparam int PAIR_WP_LO = 4;
  localparam int PAIR_WP_HI = 5;
  localparam int PAIRS = 6;
  localparam logic [7:0] SEC_NONE_CODE = 8'hA5;
  localparam logic [7:0] SEC_HIGH_CODE = 8'hCC;
  localparam logic [7:0] OB_ERASED = 8'hFF;
  localparam int USR_PARITY_BIT = 6;
  localparam int USR_VDDA_BIT = 5;
  localparam int USR_BOOT1N_BIT = 4;
  localparam int USR_STDBY_BIT = 2;
  localparam int USR_DPSLP_BIT = 1;
  localparam int USR_WDG_BIT = 0;
  localparam int PAGE_W = 7;
  localparam logic [PAGE_W-1:0] WP_LAST_FIRST_PAGE = 7'h3C;
  localparam logic [3:0] WP_LAST_GROUP = 4'hF;
  localparam logic [2:0] WS_MAX = 3'h2;

  typedef enum logic [1:0] {
    FOP_LVL_NONE = 2'h0,
    FOP_LVL_LOW = 2'h1,
    FOP_LVL_HIGH = 2'h2
  } fop_level_t;

  typedef enum logic [1:0] {
    FOP_IDLE = 2'h0,
    FOP_FETCH = 2'h1,
    FOP_APPLY = 2'h3
  } fop_fsm_t;

  typedef enum logic [2:0] {
    FOP_OP_PAGE_ERASE = 3'h0,
    FOP_OP_PROGRAM = 3'h1,
    FOP_OP_MASS_ERASE = 3'h2,
    FOP_OP_OPT_ERASE = 3'h3,
    FOP_OP_OPT_PROGRAM = 3'h4
  } fop_op_kind_t;

  typedef struct packed {
    logic req;
    fop_op_kind_t kind;
    logic [PAGE_W-1:0] page;
    logic [3:0] obyte;
    logic [7:0] data;
  } fop_op_req_t;

  typedef struct packed {
    logic done;
    logic granted;
    logic mass_erase;
  } fop_op_ans_t;

  typedef struct packed {
    logic parity_dis;
    logic vdda_mon_en;
    logic boot1_inv;
    logic stdby_noreset;
    logic dpslp_noreset;
    logic wdg_sw;
    logic [15:0] user_data;
    fop_level_t level;
    logic debug_block;
    logic [1:0] wait_states;
  } fop_opt_t;

  typedef struct packed {
    fop_fsm_t fsm;
    logic [3:0] cnt;
    logic [3:0] ob_addr;
    logic [OB_COUNT-1:0][7:0] raw;
    logic [2:0] ws_cnt;
    logic ws_en;
    logic err_en;
    logic viol;
    logic pfail;
    logic load_err;
    logic [7:0] user_byte;
    fop_opt_t opt;
    logic [15:0] wp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    fop_op_ans_t ans;
    logic bus_err;
    logic sys_rst;
    logic err_irq;
    logic [2:0] s1;
    logic [2:0] s2;
  } fop_state_t;
endpackage

//--- core/fop_top.sv
// flash option byte loader, checker and protection enforcer
// assumes option block read returns data one cycle after ob_addr,
// and that flash operations are requested on pclk by the controller
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - reset or reload request copies option block
// - complement mismatch sets error, byte becomes FF
// - A5 none, CC high, other low
// - security, user, data bytes with complements
// - protect bytes at offsets eight to eleven
// - user bits six to four decoded
// - user bits two, one: reset on sleep
// - user bit zero selects watchdog start
// - protected page operation refused, violation flagged
// - violation with error enable raises interrupt
// - protect bit zero means group protected
// - four pages per bit, last covers rest
// - option erase leaves all pages unprotected
// - no protection allows every access
// - low level restricted reads give bus error
// - low level restricted writes set program error
// - low to none by A5 mass erases
// - high level sets debug block only
// - high level refuses option erase, security byte rewrite
// - wait states 0,1,2 when enabled
// - reload request forces reload and reset
// - violation flag set by hardware, cleared by one
module fop_top
  import fop_pkg::*;
#(
  parameter int NUM_PAGES = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] ob_addr,
  input wire logic [7:0] ob_rdata,
  input wire fop_op_req_t op_in,
  output fop_op_ans_t op_out,
  input wire logic debug_mode_pin,
  input wire logic boot_sram_pin,
  input wire logic boot_loader_pin,
  input wire logic rd_req,
  input wire logic rd_main,
  output logic bus_err,
  output logic sys_reset_req,
  output logic err_irq,
  output fop_opt_t opt_out,
  output logic [15:0] page_protect_bits
);
  // the last group must own at least one page and fit the page index
  if (NUM_PAGES <= int'(WP_LAST_FIRST_PAGE) ||
      NUM_PAGES > 2**PAGE_W) begin : g_bad_pages
    $error("NUM_PAGES must be 61 to 128");
  end

  fop_state_t q;
  fop_state_t d;
  logic acc;
  logic wr;
  logic restricted;
  logic low_r;
  logic [3:0] grp;
  logic [31:0] rd_mux;
  logic unmapped;
  logic set_wp;
  logic set_pg;
  logic clr_wp;
  logic clr_pg;
  logic grant;
  logic ld_err;
  logic [PAIRS-1:0][7:0] val;
  fop_level_t lvl;

  assign acc = psel & penable & q.pready;
  assign wr = acc & pwrite;
  // synced mode pins only, first stage never read here
  assign restricted = |q.s2;
  assign low_r = (q.opt.level == FOP_LVL_LOW) & restricted;
  // last group spans to the array end
  assign grp = (op_in.page >= WP_LAST_FIRST_PAGE) ? WP_LAST_GROUP :
               op_in.page[5:2];

  always_comb begin
    d = q;
    rd_mux = '0;
    unmapped = 1'b0;
    set_wp = 1'b0;
    set_pg = 1'b0;
    grant = 1'b0;
    ld_err = 1'b0;
    val = '0;
    lvl = FOP_LVL_LOW;
    d.s1 = {debug_mode_pin, boot_sram_pin, boot_loader_pin};
    d.s2 = q.s1;
    d.sys_rst = 1'b0;
    d.ans = '0;
    d.bus_err = 1'b0;
    if (paddr == OFS_WAIT) begin
      rd_mux[2:0] = q.ws_cnt;
    end else if (paddr == OFS_STAT) begin
      rd_mux[STAT_VIOL_BIT] = q.viol;
      rd_mux[STAT_PFAIL_BIT] = q.pfail;
    end else if (paddr == OFS_CTRL) begin
      rd_mux[CTRL_ERR_EN_BIT] = q.err_en;
    end else if (paddr == OFS_OPTST) begin
      rd_mux[OPTST_ERR_BIT] = q.load_err;
      rd_mux[OPTST_LVL_LSB +: 2] = q.opt.level;
      rd_mux[OPTST_USER_LSB +: 8] = q.user_byte;
      rd_mux[OPTST_DATA_LSB +: 16] = q.opt.user_data;
    end else if (paddr == OFS_WP) begin
      rd_mux[15:0] = q.wp;
    end else if (paddr == OFS_XCFG) begin
      rd_mux[XCFG_WAIT_EN_BIT] = q.ws_en;
    end else begin
      unmapped = 1'b1;
    end
    // one wait state so every bus output comes from a flop
    d.pready = psel & penable & ~q.pready;
    d.pslverr = d.pready & unmapped;
    d.prdata = d.pready ? rd_mux : '0;
    clr_wp = wr & (paddr == OFS_STAT) & pwdata[STAT_VIOL_BIT];
    clr_pg = wr & (paddr == OFS_STAT) & pwdata[STAT_PFAIL_BIT];
    if (wr && paddr == OFS_WAIT) begin
      d.ws_cnt = pwdata[2:0];
    end
    if (wr && paddr == OFS_XCFG) begin
      d.ws_en = pwdata[XCFG_WAIT_EN_BIT];
    end
    if (wr && paddr == OFS_CTRL) begin
      d.err_en = pwdata[CTRL_ERR_EN_BIT];
    end

    case (q.fsm)
      FOP_FETCH: begin
        if (q.cnt != 4'h0) begin
          d.raw[4'(q.cnt - 4'h1)] = ob_rdata;
        end
        if (q.cnt == OB_LAST) begin
          d.fsm = FOP_APPLY;
        end else begin
          d.cnt = 4'(q.cnt + 4'h1);
          d.ob_addr = 4'(q.ob_addr + 4'h1);
        end
      end
      FOP_APPLY: begin
        for (int i = 0; i < PAIRS; i++) begin
          if ((q.raw[2*i] ^ q.raw[2*i+1]) == OB_ERASED) begin
            val[i] = q.raw[2*i];
          end else begin
            val[i] = OB_ERASED;
            ld_err = 1'b1;
          end
        end
        if (val[PAIR_SEC] == SEC_NONE_CODE) begin
          lvl = FOP_LVL_NONE;
        end else if (val[PAIR_SEC] == SEC_HIGH_CODE) begin
          lvl = FOP_LVL_HIGH;
        end
        d.load_err = ld_err;
        d.opt.level = lvl;
        d.opt.debug_block = (lvl == FOP_LVL_HIGH);
        d.user_byte = val[PAIR_USER];
        d.opt.parity_dis = val[PAIR_USER][USR_PARITY_BIT];
        d.opt.vdda_mon_en = val[PAIR_USER][USR_VDDA_BIT];
        d.opt.boot1_inv = val[PAIR_USER][USR_BOOT1N_BIT];
        d.opt.stdby_noreset = val[PAIR_USER][USR_STDBY_BIT];
        d.opt.dpslp_noreset = val[PAIR_USER][USR_DPSLP_BIT];
        d.opt.wdg_sw = val[PAIR_USER][USR_WDG_BIT];
        d.opt.user_data = {val[PAIR_DATA_HI], val[PAIR_DATA_LO]};
        // erased block reads FF, so every group ends unprotected
        d.wp = {val[PAIR_WP_HI], val[PAIR_WP_LO]};
        d.fsm = FOP_IDLE;
      end
      FOP_IDLE: begin
        if (op_in.req) begin
          case (op_in.kind)
            FOP_OP_PAGE_ERASE, FOP_OP_PROGRAM: begin
              if (low_r) begin
                set_pg = 1'b1;
              end else if (!q.wp[grp]) begin
                set_wp = 1'b1;
              end else begin
                grant = 1'b1;
              end
            end
            FOP_OP_MASS_ERASE: begin
              if (low_r) begin
                set_pg = 1'b1;
              end else begin
                grant = 1'b1;
              end
            end
            FOP_OP_OPT_ERASE: begin
              if (q.opt.level == FOP_LVL_HIGH) begin
                set_wp = 1'b1;
              end else begin
                grant = 1'b1;
              end
            end
            FOP_OP_OPT_PROGRAM: begin
              if (q.opt.level == FOP_LVL_HIGH &&
                  op_in.obyte <= OB_SEC_INV) begin
                set_wp = 1'b1;
              end else begin
                grant = 1'b1;
                d.ans.mass_erase = (q.opt.level == FOP_LVL_LOW) &&
                                   (op_in.obyte == OB_SEC) &&
                                   (op_in.data == SEC_NONE_CODE);
              end
            end
            default: begin
              grant = 1'b0;
            end
          endcase
        end
      end
      default: begin
        d.fsm = FOP_IDLE;
      end
    endcase

    // requests during a reload are answered but never granted
    d.ans.done = op_in.req;
    d.ans.granted = grant;
    d.bus_err = rd_req & rd_main & low_r;
    // a set in the clearing cycle wins
    d.viol = (q.viol & ~clr_wp) | set_wp;
    d.pfail = (q.pfail & ~clr_pg) | set_pg;
    d.err_irq = d.err_en & (d.viol | d.pfail);
    if (d.ws_en) begin
      d.opt.wait_states = (d.ws_cnt <= WS_MAX) ? d.ws_cnt[1:0] :
                          WS_MAX[1:0];
    end else begin
      d.opt.wait_states = 2'h0;
    end

    if (wr && paddr == OFS_CTRL && pwdata[CTRL_RELOAD_BIT]) begin
      d.sys_rst = 1'b1;
      d.fsm = FOP_FETCH;
      d.cnt = 4'h0;
      d.ob_addr = 4'h0;
      d.load_err = 1'b0;
      d.wp = '0;
      d.opt.level = FOP_LVL_HIGH;
      d.opt.debug_block = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.fsm <= FOP_FETCH;
      q.opt.level <= FOP_LVL_HIGH;
      q.opt.debug_block <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign ob_addr = q.ob_addr;
  assign op_out = q.ans;
  assign bus_err = q.bus_err;
  assign sys_reset_req = q.sys_rst;
  assign err_irq = q.err_irq;
  assign opt_out = q.opt;
  assign page_protect_bits = q.wp;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_reload_len;
    (q.fsm == FOP_FETCH && q.cnt == 4'h0) |-> ##13 (q.fsm == FOP_APPLY);
  endproperty
  a_reload_len: assert property (p_reload_len)
    else $error("reload did not finish in 13 cycles");

  property p_mismatch;
    (q.fsm == FOP_APPLY && (q.raw[0] ^ q.raw[1]) != OB_ERASED)
      |=> (q.load_err && q.opt.level == FOP_LVL_LOW);
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatch not flagged or not forced");

  property p_level_none;
    (q.fsm == FOP_APPLY && q.raw[0] == SEC_NONE_CODE &&
     q.raw[1] == ~SEC_NONE_CODE) |=> (q.opt.level == FOP_LVL_NONE);
  endproperty
  a_level_none: assert property (p_level_none)
    else $error("security code not decoded as none");

  property p_restrict;
    (q.fsm != FOP_IDLE) |-> (q.wp == '0 && q.opt.level == FOP_LVL_HIGH);
  endproperty
  a_restrict: assert property (p_restrict)
    else $error("settings loosened during reload");

  property p_wp_refuse;
    (q.fsm == FOP_IDLE && op_in.req && op_in.kind == FOP_OP_PAGE_ERASE
     && !low_r && !q.wp[grp])
      |=> (q.ans.done && !q.ans.granted && q.viol);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse)
    else $error("protected page erase not refused");

  property p_irq;
    (q.viol && q.err_en) |-> q.err_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("error interrupt missing");

  property p_set_wins;
    (set_wp && clr_wp) |=> q.viol;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("violation lost under clear");

  property p_reload_req;
    (wr && paddr == OFS_CTRL && pwdata[CTRL_RELOAD_BIT])
      |=> (q.sys_rst && q.fsm == FOP_FETCH) ##1 !q.sys_rst;
  endproperty
  a_reload_req: assert property (p_reload_req)
    else $error("reload request not one reset pulse");

  property p_low_program_fail_flag;
    (q.fsm == FOP_IDLE && op_in.req && op_in.kind == FOP_OP_PROGRAM &&
     low_r) |=> (q.pfail && !q.ans.granted);
  endproperty
  a_low_program_fail_flag: assert property (p_low_program_fail_flag)
    else $error("restricted program not refused");

  property p_high_opt;
    (q.fsm == FOP_IDLE && op_in.req && op_in.kind == FOP_OP_OPT_ERASE &&
     q.opt.level == FOP_LVL_HIGH) |=> !q.ans.granted;
  endproperty
  a_high_opt: assert property (p_high_opt)
    else $error("option erase granted at high level");

  property p_buserr;
    (rd_req && rd_main && low_r) |=> q.bus_err;
  endproperty
  a_buserr: assert property (p_buserr)
    else $error("restricted read without bus error");

  property p_grant;
    (q.fsm == FOP_IDLE && op_in.req && op_in.kind == FOP_OP_PROGRAM &&
     !low_r && q.wp[grp]) |=> (q.ans.done && q.ans.granted);
  endproperty
  a_grant: assert property (p_grant)
    else $error("unprotected page program refused");

  property p_erased;
    (q.fsm == FOP_APPLY && (&q.raw[2*PAIR_WP_LO +: 4])) |=> (&q.wp);
  endproperty
  a_erased: assert property (p_erased)
    else $error("erased protect bytes left pages protected");

  property p_wait;
    (q.ws_en && q.ws_cnt <= WS_MAX)
      |-> (q.opt.wait_states == q.ws_cnt[1:0]);
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait states not applied");

  c_reload: cover property (q.fsm == FOP_APPLY ##1 q.fsm == FOP_IDLE);
  c_refuse: cover property (q.ans.done && !q.ans.granted);
  c_mass: cover property (q.ans.mass_erase);
  c_slverr: cover property (q.pready && q.pslverr);
endmodule

//--- test/fop_ob_model.sv
// option block array model: twelve bytes, registered read port
// assumes the bench sets the image and holds it while a load runs
`timescale 1ns/1ps
module fop_ob_model
  import fop_pkg::*;
(
  input wire logic pclk,
  input wire logic [3:0] ob_addr,
  input wire logic [OB_COUNT-1:0][7:0] img,
  output logic [7:0] ob_rdata = 8'h3C
);
  // past the last byte nothing drives data: toggle rather than hold
  always_ff @(posedge pclk) begin
    if (ob_addr < OB_LAST) begin
      ob_rdata <= img[ob_addr];
    end else begin
      ob_rdata <= ~ob_rdata;
    end
  end
endmodule

//--- test/tb_top.sv
// bench for the flash option protection block
// assumes the option block model answers one cycle after each index
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top
  import fop_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, rd_req, rd_main, se;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, bus_err, sys_reset_req, err_irq, be;
  logic [2:0] rpin;
  logic [3:0] ob_addr;
  logic [7:0] ob_rdata;
  logic [15:0] page_protect_bits;
  logic [OB_COUNT-1:0][7:0] img;
  fop_op_req_t op_in;
  fop_op_ans_t op_out, ans;
  fop_opt_t opt_out;
  int err_total, checks;

  fop_top #(.NUM_PAGES(128)) u_fop_top (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ob_addr, .ob_rdata, .op_in, .op_out, .debug_mode_pin(rpin[0]),
    .boot_sram_pin(rpin[1]), .boot_loader_pin(rpin[2]), .rd_req,
    .rd_main, .bus_err, .sys_reset_req, .err_irq, .opt_out,
    .page_protect_bits);
  fop_ob_model u_fop_ob_model (.pclk, .ob_addr, .img, .ob_rdata);

  function automatic logic [OB_COUNT-1:0][7:0] mk(input logic [7:0] s,
      input logic [7:0] u, input logic [15:0] d, input logic [15:0] w);
    logic [5:0][7:0] v;
    logic [OB_COUNT-1:0][7:0] m;
    v = {w, d, u, s};
    for (int i = 0; i < PAIRS; i++) begin
      m[2*i] = v[i];
      m[2*i+1] = ~v[i];
    end
    return m;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input fop_op_kind_t k, input logic [6:0] pg,
      input logic [3:0] ob, input logic [7:0] d);
    @(posedge pclk);
    op_in <= '{1'b1, k, pg, ob, d};
    @(posedge pclk);
    op_in.req <= 1'b0;
    @(posedge pclk);
    ans = op_out;
  endtask

  task automatic rdm();
    @(posedge pclk);
    rd_req <= 1'b1;
    rd_main <= 1'b1;
    @(posedge pclk);
    rd_req <= 1'b0;
    rd_main <= 1'b0;
    @(posedge pclk);
    be = bus_err;
  endtask

  task automatic reload(input logic [OB_COUNT-1:0][7:0] im);
    int n;
    n = 0;
    img <= im;
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_RELOAD_BIT);
    while (sys_reset_req !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    `CHK(sys_reset_req, 1'b1)
    if (sys_reset_req !== 1'b1) begin
      wrap_up();
    end
    repeat (2) @(posedge pclk);
    `CHK(opt_out.level, FOP_LVL_HIGH)
    repeat (20) @(posedge pclk);
  endtask

  task automatic t_load();
    `CHK(opt_out.level, FOP_LVL_NONE)
    `CHK(opt_out.parity_dis, 1'b1)
    `CHK(opt_out.vdda_mon_en, 1'b0)
    `CHK(opt_out.boot1_inv, 1'b1)
    `CHK(opt_out.stdby_noreset, 1'b1)
    `CHK(opt_out.dpslp_noreset, 1'b0)
    `CHK(opt_out.wdg_sw, 1'b1)
    `CHK(page_protect_bits, 16'h7FFE)
    apb(1'b0, OFS_OPTST, 32'h0);
    `CHK(rd, 32'h1234_5500)
    $display("test load done");
  endtask

  task automatic t_regs();
    apb(1'b0, OFS_WAIT, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 1; i < 3; i++) begin
      apb(1'b1, OFS_WAIT, i);
      apb(1'b1, OFS_XCFG, 32'h1);
      repeat (3) @(posedge pclk);
      `CHK(opt_out.wait_states, i[1:0])
    end
    apb(1'b1, OFS_XCFG, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(opt_out.wait_states, 2'h0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(se, 1'b1)
    `CHK(rd, 32'h0)
    $display("test regs done");
  endtask

  task automatic t_pages();
    logic [6:0] pg [5] = '{7'h03, 7'h04, 7'h3B, 7'h3C, 7'h7F};
    logic [4:0] ok = 5'b00110;
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_ERR_EN_BIT);
    for (int i = 0; i < 5; i++) begin
      op(i[0] ? FOP_OP_PROGRAM : FOP_OP_PAGE_ERASE, pg[i], 4'h0, 8'h00);
      `CHK(ans.done, 1'b1)
      `CHK(ans.granted, ok[i])
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK(rd[STAT_VIOL_BIT], ~ok[i])
      `CHK(err_irq, ~ok[i])
      apb(1'b1, OFS_STAT, 32'h1 << STAT_VIOL_BIT);
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK(rd[STAT_VIOL_BIT], 1'b0)
      `CHK(err_irq, 1'b0)
    end
    // refusal lands on the clearing edge: the set must survive
    fork
      apb(1'b1, OFS_STAT, 32'h1 << STAT_VIOL_BIT);
      begin
        repeat (2) @(posedge pclk);
        op(FOP_OP_PAGE_ERASE, 7'h03, 4'h0, 8'h00);
      end
    join
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[STAT_VIOL_BIT], 1'b1)
    apb(1'b1, OFS_STAT, 32'h1 << STAT_VIOL_BIT);
    rpin <= 3'b001;
    repeat (4) @(posedge pclk);
    rdm();
    `CHK(be, 1'b0)
    rpin <= 3'b000;
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("test pages done");
  endtask

  task automatic t_erase();
    op(FOP_OP_OPT_ERASE, 7'h00, 4'h0, 8'h00);
    `CHK(ans.granted, 1'b1)
    reload('1);
    `CHK(page_protect_bits, 16'hFFFF)
    `CHK(opt_out.level, FOP_LVL_LOW)
    apb(1'b0, OFS_OPTST, 32'h0);
    `CHK(rd, 32'hFFFF_FF03)
    $display("test erase done");
  endtask

  task automatic t_low();
    for (int i = 0; i < 3; i++) begin
      rpin <= 3'b001 << i;
      repeat (4) @(posedge pclk);
      rdm();
      `CHK(be, 1'b1)
      op(FOP_OP_PROGRAM, 7'h0A, 4'h0, 8'h00);
      `CHK(ans.granted, 1'b0)
      apb(1'b0, OFS_STAT, 32'h0);
      `CHK(rd[STAT_PFAIL_BIT], 1'b1)
      apb(1'b1, OFS_STAT, 32'h1 << STAT_PFAIL_BIT);
    end
    op(FOP_OP_MASS_ERASE, 7'h00, 4'h0, 8'h00);
    `CHK(ans.granted, 1'b0)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[STAT_PFAIL_BIT], 1'b1)
    apb(1'b1, OFS_STAT, 32'h1 << STAT_PFAIL_BIT);
    rpin <= 3'b000;
    repeat (4) @(posedge pclk);
    rdm();
    `CHK(be, 1'b0)
    op(FOP_OP_OPT_PROGRAM, 7'h00, OB_SEC, SEC_NONE_CODE);
    `CHK(ans.mass_erase, 1'b1)
    $display("test low done");
  endtask

  task automatic t_high();
    reload(mk(SEC_HIGH_CODE, 8'h55, 16'h0000, 16'hFFFF));
    `CHK(opt_out.level, FOP_LVL_HIGH)
    `CHK(opt_out.debug_block, 1'b1)
    op(FOP_OP_OPT_ERASE, 7'h00, 4'h0, 8'h00);
    `CHK(ans.granted, 1'b0)
    op(FOP_OP_OPT_PROGRAM, 7'h00, OB_SEC, SEC_NONE_CODE);
    `CHK(ans.granted, 1'b0)
    op(FOP_OP_OPT_PROGRAM, 7'h00, OB_SEC_INV, 8'h5A);
    `CHK(ans.granted, 1'b0)
    op(FOP_OP_PROGRAM, 7'h05, 4'h0, 8'h00);
    `CHK(ans.granted, 1'b1)
    op(FOP_OP_MASS_ERASE, 7'h00, 4'h0, 8'h00);
    `CHK(ans.granted, 1'b1)
    $display("test high done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rd_req = 1'b0;
    rd_main = 1'b0;
    rpin = 3'b000;
    op_in = '0;
    err_total = 0;
    checks = 0;
    img = mk(SEC_NONE_CODE, 8'h55, 16'h1234, 16'h7FFE);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    t_load();
    t_regs();
    t_pages();
    t_erase();
    t_low();
    t_high();
    wrap_up();
  end
endmodule
